// ---- hdl/ehs_pkg.sv ----
// Shared constants, types and helpers for the e-paper host serial port
package ehs_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int REF_PERIOD_NS = 25;
  localparam int SCLK_PERIOD_NS = 1000;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * REF_PERIOD_NS);
  localparam int CS_HIGH_NS = 250;
  localparam int CS_HIGH_CYC =
    (CS_HIGH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int I2C_PERIOD_NS = 10000;
  localparam int I2C_QTR_CYC = I2C_PERIOD_NS / (4 * REF_PERIOD_NS);
  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  localparam logic [3:0] BITS_4W = 4'h8;
  localparam logic [3:0] BITS_3W = 4'h9;
  localparam logic [4:0] I2C_LAST_SLOT = 5'h1c;
  localparam logic [6:0] SENSOR_ADDR_DEF = 7'h48;
  localparam logic [6:0] SYNC_RST = 7'h53;
  // ---------------------------------------------------------------
  // Types and helpers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {EHS_REQ_CMD, EHS_REQ_DATA, EHS_REQ_READ}
    ehs_req_e;

  function automatic logic [3:0] ehs_frame_bits(input logic three_wire);
    return three_wire ? BITS_3W : BITS_4W;
  endfunction : ehs_frame_bits
endpackage : ehs_pkg

// ---- hdl/ehs_link_if.sv ----
// Link between host controller and display serial port
`timescale 1ns/1ps
interface ehs_link_if;
  logic cs_n;
  logic sclk;
  logic dc;
  logic hw_clear_n;
  logic interface_select_strap;
  logic busy;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  logic sensor_clock_out;
  logic sensor_data_o;
  logic sensor_data_oe;
  logic sensor_data_i;

  // Resolved serial data level, idle high
  assign sda = dev_sda_oe ? dev_sda_o : (host_sda_oe ? host_sda_o : 1'b1);

  modport device(
    input cs_n, sclk, dc, hw_clear_n, interface_select_strap, sda,
    input sensor_data_i,
    output busy, dev_sda_o, dev_sda_oe,
    output sensor_clock_out, sensor_data_o, sensor_data_oe
  );
  modport host(
    output cs_n, sclk, dc, hw_clear_n, host_sda_o, host_sda_oe,
    input busy, sda, interface_select_strap
  );
endinterface : ehs_link_if

// ---- hdl/ehs_fifo.sv ----
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ehs_fifo
  import ehs_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] wr_d;
  logic [AW-1:0] rd_q;
  logic [AW-1:0] rd_d;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  always_comb
  begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wr_d = push ? ((wr_q == LAST) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == LAST) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : ehs_fifo

// ---- hdl/ehs_device.sv ----
// Display-side serial command/data port with sensor reader
`timescale 1ns/1ps
// Function
// RULE1 - Serial traffic only while chip select low
// RULE2 - Four-wire: D/C high data, low command
// RULE3 - Host sends nothing while busy high
// RULE4 - Busy high during waveform or sensor access
// RULE5 - Strap low 8-bit four-wire, high 9-bit
// RULE6 - Three-wire ignores D/C; host ties low
// RULE7 - Sample data on rising clock, MSB first
// RULE8 - Host holds D/C steady per byte
// RULE9 - Route byte to data or command
// RULE10 - Four-wire read: opcode, then raise D/C
// RULE11 - Read data changes on falling edges, MSB first
// RULE12 - Chip select high ends read, output released
// RULE13 - Three-wire frame: flag bit, then eight bits
// RULE14 - Three-wire flag 1 data, 0 command
// RULE15 - Three-wire read: 0, opcode, 1, data out
// RULE16 - Hardware clear input is active low
// RULE17 - I2C master reads temperature sensor
// RULE18 - Chip select high clears bit counter
module ehs_device
  import ehs_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter logic [6:0] SENSOR_ADDR = SENSOR_ADDR_DEF,
  parameter int I2C_QTR = I2C_QTR_CYC
)(
  input wire logic ref_clk,
  input wire logic rst,
  ehs_link_if.device link,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic data_valid,
  input wire logic data_ready,
  output logic [7:0] data_byte,
  input wire logic rd_sel,
  input wire logic [7:0] rd_byte,
  output logic rd_take,
  input wire logic op_busy,
  input wire logic sensor_start,
  output logic sensor_valid,
  output logic [15:0] sensor_word
);
  typedef enum logic [2:0] {RX, RD_CHK, RD_GAP, RD_ARM, RD_OUT} ehs_dev_st_e;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic sclk_p_q;
  logic cs_s, sclk_s, sda_s, dc_s, three, clr_n_s, sensor_data_io_s;
  logic clr;
  logic rise;
  logic fall;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      sclk_p_q <= 1'b0;
    end
    else
    begin
      s1_q <= {link.cs_n, link.sclk, link.sda, link.dc,
               link.interface_select_strap, link.hw_clear_n,
               link.sensor_data_i};
      s2_q <= s1_q;
      sclk_p_q <= s2_q[5];
    end
  end

  assign {cs_s, sclk_s, sda_s, dc_s, three, clr_n_s, sensor_data_io_s} = s2_q;
  assign clr = rst | ~clr_n_s; // RULE16
  assign rise = sclk_s & ~sclk_p_q;
  assign fall = ~sclk_s & sclk_p_q;

  // ---------------------------------------------------------------
  // Serial receive and read-out engine
  // ---------------------------------------------------------------
  ehs_dev_st_e st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [8:0] sh_q, sh_d;
  logic [7:0] out_q, out_d;
  logic [2:0] obit_q, obit_d;
  logic oe_q, oe_d;
  logic cmd_v_q, cmd_v_d;
  logic [7:0] cmd_b_q, cmd_b_d;
  logic push_q, push_d;
  logic [7:0] push_b_q, push_b_d;
  logic take_q, take_d;
  logic [8:0] nsh;
  logic flag;
  logic load;

  always_comb
  begin
    nsh = {sh_q[7:0], sda_s};
    flag = 1'b0;
    load = 1'b0;
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    out_d = out_q;
    obit_d = obit_q;
    oe_d = oe_q;
    cmd_v_d = 1'b0;
    cmd_b_d = cmd_b_q;
    push_d = 1'b0;
    push_b_d = push_b_q;
    take_d = 1'b0;
    if (cs_s)
    begin
      st_d = RX; // RULE1
      bit_d = '0; // RULE18
      sh_d = '0; // RULE18
      oe_d = 1'b0; // RULE12
    end
    else
    begin
      unique case (st_q)
        RX:
        begin
          if (rise)
          begin
            sh_d = nsh; // RULE7
            if (bit_q == ehs_frame_bits(three) - 4'h1) // RULE5 RULE13
            begin
              bit_d = '0;
              flag = three ? nsh[8] : dc_s; // RULE2 RULE6 RULE8 RULE14
              if (flag)
              begin
                push_d = 1'b1; // RULE9
                push_b_d = nsh[7:0];
              end
              else
              begin
                cmd_v_d = 1'b1; // RULE9
                cmd_b_d = nsh[7:0];
                st_d = RD_CHK;
              end
            end
            else
            begin
              bit_d = bit_q + 4'h1;
            end
          end
        end
        RD_CHK:
        begin
          st_d = rd_sel ? RD_GAP : RX;
        end
        RD_GAP:
        begin
          if (three)
          begin
            if (rise)
            begin
              if (sda_s)
              begin
                st_d = RD_ARM; // RULE15
              end
              else
              begin
                st_d = RX;
                bit_d = 4'h1;
                sh_d = {8'h00, sda_s};
              end
            end
          end
          else if (dc_s)
          begin
            load = 1'b1; // RULE10
          end
        end
        RD_ARM:
        begin
          load = fall; // RULE15
        end
        RD_OUT:
        begin
          if (fall)
          begin
            if (obit_q == 3'h7)
            begin
              load = 1'b1;
            end
            else
            begin
              out_d = {out_q[6:0], 1'b0}; // RULE11
              obit_d = obit_q + 3'h1;
            end
          end
        end
      endcase
      if (load)
      begin
        st_d = RD_OUT;
        out_d = rd_byte; // RULE11
        obit_d = '0;
        oe_d = 1'b1;
        take_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      st_q <= RX;
      bit_q <= '0;
      sh_q <= '0;
      out_q <= '0;
      obit_q <= '0;
      oe_q <= 1'b0;
      cmd_v_q <= 1'b0;
      cmd_b_q <= '0;
      push_q <= 1'b0;
      push_b_q <= '0;
      take_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      out_q <= out_d;
      obit_q <= obit_d;
      oe_q <= oe_d;
      cmd_v_q <= cmd_v_d;
      cmd_b_q <= cmd_b_d;
      push_q <= push_d;
      push_b_q <= push_b_d;
      take_q <= take_d;
    end
  end

  assign cmd_valid = cmd_v_q;
  assign cmd_byte = cmd_b_q;
  assign rd_take = take_q;
  assign link.dev_sda_o = out_q[7];
  assign link.dev_sda_oe = oe_q;

  // ---------------------------------------------------------------
  // Display data buffer
  // ---------------------------------------------------------------
  logic fifo_ready;

  ehs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(clr),
    .in_valid(push_q),
    .in_ready(fifo_ready),
    .in_data(push_b_q),
    .out_valid(data_valid),
    .out_ready(data_ready),
    .out_data(data_byte)
  );

  // ---------------------------------------------------------------
  // Temperature sensor reader: start, address, two bytes, stop
  // ---------------------------------------------------------------
  logic on_q, on_d;
  logic [4:0] slot_q, slot_d;
  logic [1:0] qtr_q, qtr_d;
  logic [15:0] div_q, div_d;
  logic [15:0] rx_q, rx_d;
  logic sv_q, sv_d;
  logic scl_q, scl_d;
  logic doe_q, doe_d;
  logic busy_q;
  logic tick;
  logic [7:0] addr_b;

  always_comb
  begin
    addr_b = {SENSOR_ADDR, 1'b1};
    tick = (div_q == 16'(I2C_QTR - 1));
    on_d = on_q;
    slot_d = slot_q;
    qtr_d = qtr_q;
    div_d = div_q;
    rx_d = rx_q;
    sv_d = 1'b0;
    if (!on_q)
    begin
      if (sensor_start)
      begin
        on_d = 1'b1; // RULE17
        slot_d = '0;
        qtr_d = '0;
        div_d = '0;
      end
    end
    else if (tick)
    begin
      div_d = '0;
      qtr_d = qtr_q + 2'h1;
      if (qtr_q == 2'h2 && ((slot_q >= 5'ha && slot_q <= 5'h11) ||
          (slot_q >= 5'h13 && slot_q <= 5'h1a)))
      begin
        rx_d = {rx_q[14:0], sensor_data_io_s};
      end
      if (qtr_q == 2'h3)
      begin
        slot_d = slot_q + 5'h1;
        if (slot_q == I2C_LAST_SLOT)
        begin
          on_d = 1'b0;
          sv_d = 1'b1;
        end
      end
    end
    else
    begin
      div_d = div_q + 16'h1;
    end
    scl_d = 1'b1;
    doe_d = 1'b0;
    if (on_q)
    begin
      if (slot_q == 5'h0)
      begin
        scl_d = (qtr_q != 2'h3);
        doe_d = (qtr_q != 2'h0);
      end
      else if (slot_q == I2C_LAST_SLOT)
      begin
        scl_d = (qtr_q != 2'h0);
        doe_d = (qtr_q < 2'h2);
      end
      else
      begin
        scl_d = (qtr_q == 2'h1) || (qtr_q == 2'h2);
        if (slot_q <= 5'h8)
        begin
          doe_d = ~addr_b[3'(5'h8 - slot_q)];
        end
        else
        begin
          doe_d = (slot_q == 5'h12);
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      on_q <= 1'b0;
      slot_q <= '0;
      qtr_q <= '0;
      div_q <= '0;
      rx_q <= '0;
      sv_q <= 1'b0;
      scl_q <= 1'b1;
      doe_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      on_q <= on_d;
      slot_q <= slot_d;
      qtr_q <= qtr_d;
      div_q <= div_d;
      rx_q <= rx_d;
      sv_q <= sv_d;
      scl_q <= scl_d;
      doe_q <= doe_d;
      busy_q <= op_busy | on_q | ~fifo_ready; // RULE4
    end
  end

  assign sensor_valid = sv_q;
  assign sensor_word = rx_q;
  assign link.sensor_clock_out = scl_q;
  assign link.sensor_data_o = 1'b0;
  assign link.sensor_data_oe = doe_q;
  assign link.busy = busy_q;
endmodule : ehs_device

// ---- hdl/ehs_host.sv ----
// Host-side serial master for the display port
`timescale 1ns/1ps
module ehs_host
  import ehs_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYC,
  parameter int CS_GAP = CS_HIGH_CYC
)(
  input wire logic ref_clk,
  input wire logic rst,
  ehs_link_if.host link,
  input wire logic clear_req,
  input wire logic req_valid,
  output logic req_ready,
  input wire ehs_req_e req_kind,
  input wire logic [7:0] req_byte,
  input wire logic [3:0] req_len,
  output logic rd_valid,
  output logic [7:0] rd_byte
);
  typedef enum logic [2:0] {IDLE, SETUP, SHIFT, TURN, RDBITS, GAP}
    ehs_host_st_e;

  // ---------------------------------------------------------------
  // Synchronisers for device outputs and the interface strap
  // ---------------------------------------------------------------
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic busy_s;
  logic sda_s;
  logic three;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end
    else
    begin
      s1_q <= {link.busy, link.sda, link.interface_select_strap};
      s2_q <= s1_q;
    end
  end
  assign {busy_s, sda_s, three} = s2_q;

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  ehs_host_st_e st_q, st_d;
  logic [7:0] hc_q, hc_d;
  logic [9:0] tx_q, tx_d;
  logic [3:0] bits_q, bits_d;
  logic [3:0] len_q, len_d;
  logic [7:0] rx_q, rx_d;
  logic cs_q, cs_d, sclk_q, sclk_d, dc_q, dc_d, oe_q, oe_d;
  logic rv_q, rv_d, rd_q, rd_d, clr_q;
  logic half;

  assign half = (hc_q == 8'(SCLK_HALF - 1));
  assign req_ready = (st_q == IDLE) & ~busy_s; // RULE3

  always_comb
  begin
    st_d = st_q;
    hc_d = half ? 8'h0 : hc_q + 8'h1;
    tx_d = tx_q;
    bits_d = bits_q;
    len_d = len_q;
    rx_d = rx_q;
    cs_d = cs_q;
    sclk_d = sclk_q;
    dc_d = dc_q;
    oe_d = oe_q;
    rv_d = 1'b0;
    rd_d = rd_q;
    unique case (st_q)
      IDLE:
      begin
        hc_d = '0;
        if (req_valid & req_ready)
        begin
          st_d = SETUP;
          cs_d = 1'b0;
          oe_d = 1'b1;
          rd_d = (req_kind == EHS_REQ_READ);
          len_d = req_len;
          dc_d = (req_kind == EHS_REQ_DATA) & ~three; // RULE6 RULE8
          bits_d = ehs_frame_bits(three);
          if (three && req_kind == EHS_REQ_READ)
          begin
            tx_d = {1'b0, req_byte, 1'b1}; // RULE15
            bits_d = BITS_3W + 4'h1;
          end
          else if (three)
          begin
            tx_d = {req_kind == EHS_REQ_DATA, req_byte, 1'b0};
          end
          else
          begin
            tx_d = {req_byte, 2'b00};
          end
        end
      end
      SETUP:
      begin
        if (half)
        begin
          sclk_d = 1'b1;
          st_d = SHIFT;
        end
      end
      SHIFT:
      begin
        if (half)
        begin
          sclk_d = ~sclk_q;
          if (!sclk_q)
          begin
            tx_d = tx_q;
          end
          else if (bits_q == 4'h1)
          begin
            st_d = rd_q ? TURN : GAP;
            oe_d = 1'b0;
            dc_d = rd_q & ~three; // RULE10
            cs_d = ~rd_q;
          end
          else
          begin
            tx_d = {tx_q[8:0], 1'b0};
            bits_d = bits_q - 4'h1;
          end
        end
      end
      TURN:
      begin
        bits_d = BITS_4W;
        if (half)
        begin
          st_d = RDBITS;
        end
      end
      RDBITS:
      begin
        if (half)
        begin
          sclk_d = ~sclk_q;
          if (!sclk_q)
          begin
            rx_d = {rx_q[6:0], sda_s};
          end
          else if (bits_q == 4'h1)
          begin
            rv_d = 1'b1;
            bits_d = BITS_4W;
            len_d = len_q - 4'h1;
            if (len_q <= 4'h1)
            begin
              st_d = GAP;
              cs_d = 1'b1; // RULE12
              dc_d = 1'b0;
            end
          end
          else
          begin
            bits_d = bits_q - 4'h1;
          end
        end
      end
      GAP:
      begin
        // Own count: the half-period wrap may be shorter than the gap
        hc_d = hc_q + 8'h1;
        if (hc_q == 8'(CS_GAP - 1))
        begin
          st_d = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q <= IDLE;
      hc_q <= '0;
      tx_q <= '0;
      bits_q <= '0;
      len_q <= '0;
      rx_q <= '0;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      dc_q <= 1'b0;
      oe_q <= 1'b0;
      rv_q <= 1'b0;
      rd_q <= 1'b0;
      clr_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      hc_q <= hc_d;
      tx_q <= tx_d;
      bits_q <= bits_d;
      len_q <= len_d;
      rx_q <= rx_d;
      cs_q <= cs_d;
      sclk_q <= sclk_d;
      dc_q <= dc_d;
      oe_q <= oe_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      clr_q <= clear_req;
    end
  end

  assign link.cs_n = cs_q;
  assign link.sclk = sclk_q;
  assign link.dc = dc_q;
  assign link.host_sda_o = tx_q[9];
  assign link.host_sda_oe = oe_q;
  assign link.hw_clear_n = ~clr_q;
  assign rd_valid = rv_q;
  assign rd_byte = rx_q;
endmodule : ehs_host

// ---- verif/ehs_link_chk.sv ----
// Concurrent checks on the host serial link
`timescale 1ns/1ps
module ehs_link_chk
  import ehs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dc,
  input wire logic hw_clear_n,
  input wire logic interface_select_strap,
  input wire logic busy,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sensor_clock_out,
  input wire logic sensor_data_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // Rising clock count per frame
  // ---------------------------------------------------------------
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic seen_q;
  logic seen_d;
  logic sclk_q;

  always_comb
  begin
    cnt_d = cnt_q;
    seen_d = seen_q;
    if (cs_n)
    begin
      cnt_d = 5'h0;
      seen_d = 1'b0;
    end
    else
    begin
      if (sclk && !sclk_q)
        cnt_d = cnt_q + 5'h1;
      if (dev_sda_oe)
        seen_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_q <= 5'h0;
      seen_q <= 1'b0;
      sclk_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      seen_q <= seen_d;
      sclk_q <= sclk;
    end
  end

  // ---------------------------------------------------------------
  // Sequences and assertions
  // ---------------------------------------------------------------
  sequence s_cs_idle;
    cs_n [*8];
  endsequence
  sequence s_clear;
    !hw_clear_n [*6];
  endsequence
  sequence s_busy_run;
    busy [*6];
  endsequence

  AST_IDLE_RELEASE: assert property (s_cs_idle |-> !dev_sda_oe)
    else $error("read data driven while deselected");
  AST_END_RELEASE: assert property ($rose(cs_n) |-> ##[1:6] !dev_sda_oe)
    else $error("read data not released after deselect");
  AST_FALL_CHANGE: assert property (dev_sda_oe && $past(dev_sda_oe)
    && $changed(dev_sda_o) |-> !sclk)
    else $error("read data changed while clock high");
  AST_DC_STEADY: assert property (!interface_select_strap && !cs_n
    && $changed(dc) |-> !sclk)
    else $error("dc moved while clock high");
  AST_DC_TIED: assert property (interface_select_strap && !cs_n |-> !dc)
    else $error("dc not low in three-wire");
  AST_BUSY_HOLD: assert property (s_busy_run |=> !$fell(cs_n))
    else $error("frame started while busy");
  AST_SENSOR_BUSY: assert property (!sensor_clock_out |-> busy)
    else $error("sensor access without busy");
  AST_SENSOR_DATA: assert property ($rose(sensor_clock_out)
    |-> $stable(sensor_data_oe))
    else $error("sensor data moved at clock rise");
  AST_CLEAR: assert property (s_clear
    |-> !busy && !dev_sda_oe && sensor_clock_out)
    else $error("device not cleared");
  AST_FRAME_BITS: assert property ($rose(cs_n) && !seen_q
    |-> cnt_q == {1'b0, (interface_select_strap ? BITS_3W : BITS_4W)})
    else $error("wrong bit count in write frame");
endmodule : ehs_link_chk

// ---- verif/epaper_host_serial_port_bench.sv ----
// Bench joining host and device ends of the serial port
`timescale 1ns/1ps
module epaper_host_serial_port_bench;
  import ehs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clear_req = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready;
  ehs_req_e req_kind = EHS_REQ_CMD;
  logic [7:0] req_byte = 8'h00;
  logic [3:0] req_len = 4'h1;
  logic rd_valid, cmd_valid, data_valid, rd_take, sensor_valid;
  logic [7:0] h_rd_byte, cmd_byte, data_byte;
  logic [15:0] sensor_word;
  logic data_ready = 1'b1;
  logic rd_sel = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic op_busy = 1'b0;
  logic sensor_start = 1'b0;
  logic strap = 1'b0;
  logic [7:0] cmd_q[$], data_q[$], rd_q[$];
  logic [15:0] word_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;

  ehs_link_if link_i();
  assign link_i.interface_select_strap = strap;
  assign link_i.sensor_data_i = ~link_i.sensor_data_oe;

  ehs_host #(.SCLK_HALF(8)) u_ehs_host (.ref_clk(ref_clk), .rst(rst),
    .link(link_i.host), .clear_req(clear_req), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_byte(req_byte),
    .req_len(req_len), .rd_valid(rd_valid), .rd_byte(h_rd_byte));
  ehs_device #(.I2C_QTR(4)) u_ehs_device (.ref_clk(ref_clk), .rst(rst),
    .link(link_i.device), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .data_valid(data_valid), .data_ready(data_ready),
    .data_byte(data_byte), .rd_sel(rd_sel), .rd_byte(rd_byte),
    .rd_take(rd_take), .op_busy(op_busy), .sensor_start(sensor_start),
    .sensor_valid(sensor_valid), .sensor_word(sensor_word));
  ehs_link_chk u_ehs_link_chk (.ref_clk(ref_clk), .rst(rst),
    .cs_n(link_i.cs_n), .sclk(link_i.sclk), .dc(link_i.dc),
    .hw_clear_n(link_i.hw_clear_n),
    .interface_select_strap(link_i.interface_select_strap),
    .busy(link_i.busy), .dev_sda_o(link_i.dev_sda_o),
    .dev_sda_oe(link_i.dev_sda_oe),
    .sensor_clock_out(link_i.sensor_clock_out),
    .sensor_data_oe(link_i.sensor_data_oe));

  always #12.5 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // Monitors and read byte source
  // ---------------------------------------------------------------
  always @(negedge ref_clk)
  begin
    if (cmd_valid === 1'b1) cmd_q.push_back(cmd_byte);
    if (data_valid === 1'b1 && data_ready) data_q.push_back(data_byte);
    if (rd_valid === 1'b1) rd_q.push_back(h_rd_byte);
    if (sensor_valid === 1'b1) word_q.push_back(sensor_word);
    if (rd_take === 1'b1) rd_byte <= rd_byte + 8'h01;
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task send(input ehs_req_e k, input logic [7:0] b, input logic [3:0] l);
    for (n = 0; n < 3000 && req_ready !== 1'b1; n++) @(negedge ref_clk);
    chk(req_ready, 16'h1);
    req_kind = k;
    req_byte = b;
    req_len = l;
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask : send

  task settle(input int want);
    for (n = 0; n < 3000 && (cmd_q.size() + rd_q.size() < want ||
         req_ready !== 1'b1); n++)
      @(negedge ref_clk);
    chk(req_ready, 16'h1);
    repeat (40) @(negedge ref_clk);
  endtask : settle

  task results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_write(input logic s);
    strap = s;
    repeat (4) @(negedge ref_clk);
    send(EHS_REQ_CMD, 8'h5a, 4'h1);
    send(EHS_REQ_DATA, 8'hb7, 4'h1);
    settle(1);
    chk(cmd_q.size(), 16'h1);
    chk(cmd_q.pop_front(), 16'h5a);
    chk(data_q.size(), 16'h1);
    chk(data_q.pop_front(), 16'hb7);
    $display("write test done, three-wire %b", s);
  endtask : t_write

  task t_read(input logic s);
    strap = s;
    repeat (4) @(negedge ref_clk);
    rd_sel = 1'b1;
    rd_byte = 8'hc3;
    send(EHS_REQ_READ, 8'h2f, 4'h2);
    settle(3);
    chk(cmd_q.pop_front(), 16'h2f);
    chk(rd_q.size(), 16'h2);
    chk(rd_q.pop_front(), 16'hc3);
    chk(rd_q.pop_front(), 16'hc4);
    chk(link_i.dev_sda_oe, 16'h0);
    rd_sel = 1'b0;
    $display("read test done, three-wire %b", s);
  endtask : t_read

  task t_fifo;
    data_ready = 1'b0;
    for (int i = 0; i < 8; i++) send(EHS_REQ_DATA, 8'h10 + i, 4'h1);
    repeat (200) @(negedge ref_clk);
    chk(link_i.busy, 16'h1);
    chk(req_ready, 16'h0);
    data_ready = 1'b1;
    repeat (20) @(negedge ref_clk);
    chk(data_q.size(), 16'h8);
    for (int i = 0; i < 8; i++) chk(data_q.pop_front(), 16'h10 + i);
    $display("fifo test done");
  endtask : t_fifo

  task t_busy_clear;
    op_busy = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk(link_i.busy, 16'h1);
    chk(req_ready, 16'h0);
    clear_req = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk(link_i.busy, 16'h0);
    clear_req = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk(link_i.busy, 16'h1);
    op_busy = 1'b0;
    repeat (5) @(negedge ref_clk);
    $display("busy and clear test done");
  endtask : t_busy_clear

  task t_sensor;
    sensor_start = 1'b1;
    @(negedge ref_clk);
    sensor_start = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(link_i.busy, 16'h1);
    for (n = 0; n < 3000 && word_q.size() == 0; n++) @(negedge ref_clk);
    chk(word_q.size(), 16'h1);
    chk(word_q.pop_front(), 16'hffff);
    repeat (5) @(negedge ref_clk);
    chk(link_i.busy, 16'h0);
    $display("sensor test done");
  endtask : t_sensor

  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_write(1'b0);
    t_read(1'b0);
    t_fifo();
    t_write(1'b1);
    t_read(1'b1);
    strap = 1'b0;
    t_busy_clear();
    t_sensor();
    results();
  end
endmodule : epaper_host_serial_port_bench
